// >>> mcr_dec3.v
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.vh"
module mcr_dec3 (
  // Binary value in
  input wire [9:0] val,
  // ASCII digits out
  output wire [7:0] d_h,
  output wire [7:0] d_t,
  output wire [7:0] d_o
);
  wire [9:0] v;
  wire [9:0] h;
  wire [9:0] t;
  wire [9:0] o;

  // Values above three digits clamp rather than wrap
  assign v = (val > `MCR_DEC_SAT) ? `MCR_DEC_SAT : val;
  assign h = v / `MCR_DEC_100;
  assign t = (v / `MCR_DEC_10) % `MCR_DEC_10;
  assign o = v % `MCR_DEC_10;
  assign d_h = `MCR_C_ZERO + {4'h0, h[3:0]};
  assign d_t = `MCR_C_ZERO + {4'h0, t[3:0]};
  assign d_o = `MCR_C_ZERO + {4'h0, o[3:0]};
endmodule // mcr_dec3
`default_nettype wire

// >>> mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model (
  // Clock
  input wire core_clk,
  // Request stream
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire rx_ready,
  // Reply stream
  input wire tx_valid_q,
  input wire [7:0] tx_data_q,
  input wire tx_last_q,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic fin = 1'b0;
  logic [255:0] rep = '0;
  integer cnt = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b1;
  end
  // Slow mode stalls every other cycle
  always @(posedge core_clk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (tx_valid_q && tx_ready) begin
      rep <= {rep[247:0], tx_data_q};
      cnt <= cnt + 1;
      fin <= tx_last_q;
    end
  end
  task clear;
    begin
      rep = '0;
      cnt = 0;
      fin = 1'b0;
    end
  endtask
  // Marker first; each byte held until taken
  task send(input [63:0] f, input integer n);
    integer i;
    begin
      for (i = n - 1; i >= 0; i--) begin
        rx_valid <= 1'b1;
        rx_data <= f[8*i+:8];
        rx_last <= (i == 0);
        @(negedge core_clk);
        while (!rx_ready) @(negedge core_clk);
        @(posedge core_clk);
      end
      rx_valid <= 1'b0;
      rx_last <= 1'b0;
      rx_data <= ~rx_data;
    end
  endtask
endmodule // mcr_host_model
`default_nettype wire

// >>> mcr_map.vh
`ifndef MCR_MAP_VH
`define MCR_MAP_VH
// ****************************************
// Message framing and return codes
// ****************************************
`define MCR_MARK 8'h43
`define MCR_RC_Y 8'h59
`define MCR_RC_N 8'h4E
`define MCR_RC_Q 8'h3F
`define MCR_POS_MARK 2'h0
`define MCR_POS_IDX 2'h1
`define MCR_POS_CMD 2'h2
`define MCR_POS_DATA 2'h3
// ****************************************
// Command characters
// ****************************************
`define MCR_CMD_ST 8'h31
`define MCR_CMD_STE 8'h45
`define MCR_CMD_STM 8'h4D
`define MCR_CMD_ALM 8'h4C
`define MCR_CMD_MSG 8'h47
`define MCR_CMD_TST 8'h54
`define MCR_CMD_CMB 8'h4E
`define MCR_CMD_ID 8'h30
`define MCR_CMD_FW 8'h46
`define MCR_CMD_SN 8'h49
`define MCR_CMD_LIM 8'h43
`define MCR_CMD_CFG 8'h50
`define MCR_CMD_START 8'h35
`define MCR_CMD_STOP 8'h36
`define MCR_CMD_STBY 8'h37
`define MCR_CMD_ONL 8'h38
// ****************************************
// Reply characters
// ****************************************
`define MCR_C_DASH 8'h2D
`define MCR_C_SEMI 8'h3B
`define MCR_C_PLUS 8'h2B
`define MCR_C_EQ 8'h3D
`define MCR_C_DOT 8'h2E
`define MCR_C_COLON 8'h3A
`define MCR_C_UNDS 8'h5F
`define MCR_C_ZERO 8'h30
`define MCR_C_ONE 8'h31
`define MCR_C_A 8'h41
`define MCR_C_B 8'h42
`define MCR_C_C 8'h43
`define MCR_C_D 8'h44
`define MCR_C_E 8'h45
`define MCR_C_I 8'h49
`define MCR_C_L 8'h4C
`define MCR_C_M 8'h4D
`define MCR_C_O 8'h4F
`define MCR_C_P 8'h50
`define MCR_C_R 8'h52
`define MCR_C_S 8'h53
`define MCR_C_T 8'h54
`define MCR_C_X 8'h58
`define MCR_C_LOWER 8'h20
// ****************************************
// Port types and operating states
// ****************************************
`define MCR_PT_IN 3'h0
`define MCR_PT_OUT 3'h1
`define MCR_PT_CRIT 3'h2
`define MCR_PT_BLEED 3'h3
`define MCR_OS_RED 4'h0
`define MCR_OS_PAR 4'h1
`define MCR_OS_SOLO 4'h2
`define MCR_OS_TEST 4'h3
`define MCR_OS_TRAN 4'h4
`define MCR_OS_COMM 4'h5
`define MCR_OS_MAN 4'h6
`define MCR_OS_OFF 4'h7
// ****************************************
// Field positions and lengths
// ****************************************
`define MCR_ST_STATE 4'h1
`define MCR_ST_PORT 4'h2
`define MCR_ST_ALARM 4'h3
`define MCR_ST_PRESS 4'h4
`define MCR_ST_SIGN 4'h7
`define MCR_ST_TEMP 4'h8
`define MCR_ST_DUTY 4'hB
`define MCR_ST_LAST 4'hD
`define MCR_HEX_LAST 4'h3
`define MCR_T_MIN 4'h3
`define MCR_T_SEC 4'h6
`define MCR_T_LAST 4'h9
`define MCR_T_RATE 4'h4
`define MCR_LIM_LAST 4'hC
`define MCR_CFG_LAST 4'h7
`define MCR_STR_LAST 4'h7
`define MCR_STR_TERM 4'h8
`define MCR_PORT_SEG 4'h8
`define MCR_TPORT_SEG 4'h9
`define MCR_MSG_NONE 4'h7
`define MCR_DEC_SAT 10'h3E7
`define MCR_DEC_100 10'h064
`define MCR_DEC_10 10'h00A
`define MCR_TYPE_W 3
`define MCR_ALM_W 8
`define MCR_VAL_W 10
`endif

// >>> mcr_responder.v
// Contract
// - Request is marker, index, command, optional data
// - Reply leads with Y, N or ? code
// - Status string fourteen chars, units first
// - Chars one two give state, port
// - Char three is alarm flag
// - Pressure, signed temperature, duty or dashes
// - Alarm list: global hex word, eight ports
// - Port alarm hex, dot prefix if disabled
// - Global alarm bit zero is alarm one
// - Port alarm bits map eight leak conditions
// - Combined reply: word plus type, alarm groups
// - Leak rates three digits, saturate, semicolons
// - Time field X or hours minutes seconds
// - System leak field S then dash/rate
// - Port test fields: type, open, extras
// - Type letters; I, O and C lower case when disabled
// - Message codes list, XX when none
// - Identity strings, semicolon separated fields
// - Limits: units letter, four decimal values
// - Port configuration is eight type letters
// - Start and standby may refuse; stop and online accept
// - Single-byte commands, same set everywhere
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.vh"
module mcr_responder #(
  // Identity strings, eight ASCII chars each; values are arbitrary
  parameter [63:0] MODEL_ID = 64'h4D43522D30303031,
  parameter [63:0] FW_MAIN = 64'h4D41494E2D303130,
  parameter [63:0] FW_COMM = 64'h434F4D4D2D303130,
  parameter [63:0] BOARD_SN = 64'h4230303030303031,
  parameter [63:0] PART_NO = 64'h5030303030303031,
  parameter [63:0] UNIT_SN = 64'h5530303030303031
) (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Request stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  output wire rx_ready,
  // Reply stream
  output reg tx_valid_q,
  output reg [7:0] tx_data_q,
  output reg tx_last_q,
  input wire tx_ready,
  // Unit state
  input wire units_metric,
  input wire [3:0] op_state,
  input wire [2:0] active_port,
  input wire [15:0] global_alarm,
  input wire [63:0] port_alarm,
  input wire [23:0] port_type,
  input wire [7:0] port_disabled,
  input wire [7:0] port_open,
  input wire [7:0] port_in_use,
  // Measurements
  input wire [9:0] press_eng,
  input wire [9:0] press_met,
  input wire temp_eng_neg,
  input wire [9:0] temp_eng,
  input wire temp_met_neg,
  input wire [9:0] temp_met,
  input wire duty_avail,
  input wire [9:0] duty,
  input wire [39:0] limits,
  // Test results and messages
  input wire test_done,
  input wire [9:0] test_hours,
  input wire [5:0] test_min,
  input wire [5:0] test_sec,
  input wire sys_leak_avail,
  input wire [9:0] sys_leak,
  input wire [7:0] port_leak_avail,
  input wire [79:0] port_leak,
  input wire [6:0] msg_flags,
  // Action permission and strobes
  input wire can_test,
  input wire can_standby,
  output reg start_test_q,
  output reg stop_test_q,
  output reg go_standby_q,
  output reg go_online_q
);
  // ****************************************
  // Helpers
  // ****************************************
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_HDR = 2'h1;
  localparam [1:0] S_BODY = 2'h2;
  localparam [1:0] S_DONE = 2'h3;

  function [7:0] hex_ch;
    input [3:0] n;
    begin
      hex_ch = (n < 4'hA) ? (`MCR_C_ZERO + {4'h0, n}) : (`MCR_C_A + {4'h0, n - 4'hA});
    end
  endfunction

  function [7:0] type_ch;
    input [2:0] t;
    input dis;
    begin
      case (t)
        `MCR_PT_IN: type_ch = `MCR_C_I;
        `MCR_PT_OUT: type_ch = `MCR_C_O;
        `MCR_PT_CRIT: type_ch = `MCR_C_C;
        `MCR_PT_BLEED: type_ch = `MCR_C_B;
        default: type_ch = `MCR_C_X;
      endcase
      if (dis && (t <= `MCR_PT_CRIT)) begin
        type_ch = type_ch | `MCR_C_LOWER;
      end
    end
  endfunction

  function is_ioc;
    input [2:0] t;
    begin
      is_ioc = (t <= `MCR_PT_CRIT);
    end
  endfunction

  function [7:0] state_ch;
    input [3:0] s;
    begin
      case (s)
        `MCR_OS_RED: state_ch = `MCR_C_R;
        `MCR_OS_PAR: state_ch = `MCR_C_P;
        `MCR_OS_SOLO: state_ch = `MCR_C_S;
        `MCR_OS_TEST: state_ch = `MCR_C_T;
        `MCR_OS_TRAN: state_ch = `MCR_C_I;
        `MCR_OS_COMM: state_ch = `MCR_C_C;
        `MCR_OS_MAN: state_ch = `MCR_C_M;
        `MCR_OS_OFF: state_ch = `MCR_C_O;
        default: state_ch = `MCR_C_X;
      endcase
    end
  endfunction

  // Message table order: XD XP XT EC EL EP TA
  function [7:0] msg_ch;
    input [2:0] i;
    input second;
    begin
      case (i)
        3'h0: msg_ch = second ? `MCR_C_D : `MCR_C_X;
        3'h1: msg_ch = second ? `MCR_C_P : `MCR_C_X;
        3'h2: msg_ch = second ? `MCR_C_T : `MCR_C_X;
        3'h3: msg_ch = second ? `MCR_C_C : `MCR_C_E;
        3'h4: msg_ch = second ? `MCR_C_L : `MCR_C_E;
        3'h5: msg_ch = second ? `MCR_C_P : `MCR_C_E;
        default: msg_ch = second ? `MCR_C_A : `MCR_C_T;
      endcase
    end
  endfunction

  function [2:0] top_flag;
    input [6:0] f;
    integer k;
    begin
      top_flag = 3'h0;
      for (k = 0; k < 7; k = k + 1) begin
        if (f[k]) begin
          top_flag = k[2:0];
        end
      end
    end
  endfunction

  function is_query;
    input [7:0] c;
    begin
      case (c)
        `MCR_CMD_ST, `MCR_CMD_STE, `MCR_CMD_STM, `MCR_CMD_ALM, `MCR_CMD_MSG, `MCR_CMD_TST,
        `MCR_CMD_CMB, `MCR_CMD_ID, `MCR_CMD_FW, `MCR_CMD_SN, `MCR_CMD_LIM, `MCR_CMD_CFG: is_query = 1'b1;
        default: is_query = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Request intake
  // ****************************************
  reg [1:0] state_q;
  reg [1:0] hpos_q;
  reg [3:0] seg_q;
  reg [3:0] sub_q;
  reg [7:0] idx_q;
  reg [7:0] cmd_q;
  reg [7:0] rc_q;
  reg [7:0] rc_d;
  wire req;
  wire req_mark_ok;
  wire [7:0] req_idx;
  wire [7:0] req_cmd;
  wire adv;
  wire has_body;

  // One request at a time: intake stalls until the reply has gone
  assign rx_ready = (state_q == S_IDLE);
  assign adv = ~tx_valid_q | tx_ready;
  assign has_body = is_query(cmd_q);

  mcr_rx_frame u_rx (
    .core_clk(core_clk),
    .rst(rst),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_last(rx_last),
    .rx_ready(rx_ready),
    .req_q(req),
    .mark_ok_q(req_mark_ok),
    .idx_q(req_idx),
    .cmd_q(req_cmd)
  );

  always @* begin
    rc_d = `MCR_RC_Q;
    if (is_query(req_cmd)) begin
      rc_d = `MCR_RC_Y;
    end else begin
      case (req_cmd)
        `MCR_CMD_START: rc_d = can_test ? `MCR_RC_Y : `MCR_RC_N;
        `MCR_CMD_STBY: rc_d = can_standby ? `MCR_RC_Y : `MCR_RC_N;
        `MCR_CMD_STOP, `MCR_CMD_ONL: rc_d = `MCR_RC_Y;
        default: rc_d = `MCR_RC_Q;
      endcase
    end
  end

  // ****************************************
  // Reply body character generator
  // ****************************************
  reg [7:0] lit;
  reg use_dig;
  reg [9:0] dval;
  reg [3:0] soff;
  reg seg_end;
  reg body_end;
  reg skip;
  reg [3:0] ptmp;
  reg [63:0] str;
  reg term;
  reg [3:0] lk;
  wire [2:0] pi;
  wire [2:0] ptype;
  wire pdis;
  wire [7:0] palm;
  wire met;
  wire any_alarm;
  wire [7:0] d_h;
  wire [7:0] d_t;
  wire [7:0] d_o;
  wire [7:0] dig;
  wire [7:0] body_ch;
  wire [3:0] gnib;

  assign pi = ptmp[2:0];
  assign ptype = port_type[pi * `MCR_TYPE_W +: `MCR_TYPE_W];
  assign pdis = port_disabled[pi];
  assign palm = port_alarm[pi * `MCR_ALM_W +: `MCR_ALM_W];
  assign met = (cmd_q == `MCR_CMD_STM) | ((cmd_q == `MCR_CMD_ST) & units_metric);
  assign any_alarm = (|global_alarm) | (|port_alarm);
  assign gnib = global_alarm[(`MCR_HEX_LAST - sub_q) * 4 +: 4];
  assign dig = (soff[1:0] == 2'h0) ? d_h : ((soff[1:0] == 2'h1) ? d_t : d_o);
  assign body_ch = use_dig ? dig : lit;

  mcr_dec3 u_dec (
    .val(dval),
    .d_h(d_h),
    .d_t(d_t),
    .d_o(d_o)
  );

  always @* begin
    lit = `MCR_C_DASH;
    use_dig = 1'b0;
    dval = 10'h000;
    soff = 4'h0;
    seg_end = 1'b0;
    body_end = 1'b0;
    skip = 1'b0;
    str = MODEL_ID;
    term = 1'b0;
    lk = 4'h0;
    ptmp = (cmd_q == `MCR_CMD_TST) ? (seg_q - 4'h2) : (seg_q - 4'h1);
    case (cmd_q)
      `MCR_CMD_ST, `MCR_CMD_STE, `MCR_CMD_STM: begin
        seg_end = (sub_q == `MCR_ST_LAST);
        body_end = seg_end;
        if (sub_q < `MCR_ST_STATE) begin
          lit = met ? `MCR_C_M : `MCR_C_E;
        end else if (sub_q == `MCR_ST_STATE) begin
          lit = state_ch(op_state);
        end else if (sub_q == `MCR_ST_PORT) begin
          lit = (op_state == `MCR_OS_RED) ? (`MCR_C_ONE + {5'h00, active_port}) : `MCR_C_UNDS;
        end else if (sub_q == `MCR_ST_ALARM) begin
          lit = any_alarm ? `MCR_C_A : `MCR_C_DASH;
        end else if (sub_q < `MCR_ST_SIGN) begin
          use_dig = 1'b1;
          dval = met ? press_met : press_eng;
          soff = sub_q - `MCR_ST_PRESS;
        end else if (sub_q == `MCR_ST_SIGN) begin
          lit = (met ? temp_met_neg : temp_eng_neg) ? `MCR_C_DASH : `MCR_C_PLUS;
        end else if (sub_q < `MCR_ST_DUTY) begin
          use_dig = 1'b1;
          dval = met ? temp_met : temp_eng;
          soff = sub_q - `MCR_ST_TEMP;
        end else begin
          use_dig = duty_avail;
          dval = duty;
          soff = sub_q - `MCR_ST_DUTY;
        end
      end
      `MCR_CMD_ALM, `MCR_CMD_CMB: begin
        if (seg_q == 4'h0) begin
          lit = hex_ch(gnib);
          seg_end = (sub_q == `MCR_HEX_LAST);
        end else if (cmd_q == `MCR_CMD_ALM) begin
          // Disabled ports gain a leading dot, so the reply runs 23 to 31 chars
          soff = pdis ? sub_q : (sub_q + 4'h1);
          lit = (soff == 4'h0) ? `MCR_C_DOT : ((soff == 4'h1) ? hex_ch(palm[7:4]) : hex_ch(palm[3:0]));
          seg_end = (soff == 4'h2);
          body_end = (seg_q == `MCR_PORT_SEG);
        end else begin
          lit = (sub_q == 4'h0) ? type_ch(ptype, pdis) : ((sub_q == 4'h1) ? hex_ch(palm[7:4]) : hex_ch(palm[3:0]));
          seg_end = (sub_q == 4'h2);
          body_end = (seg_q == `MCR_PORT_SEG);
        end
      end
      `MCR_CMD_TST: begin
        if (seg_q == 4'h0) begin
          if (!test_done) begin
            lit = (sub_q == 4'h0) ? `MCR_C_X : `MCR_C_SEMI;
            seg_end = (sub_q == 4'h1);
          end else begin
            seg_end = (sub_q == `MCR_T_LAST);
            if (sub_q < `MCR_T_MIN) begin
              use_dig = 1'b1;
              dval = test_hours;
              soff = sub_q;
            end else if ((sub_q == `MCR_T_MIN) || (sub_q == `MCR_T_SEC)) begin
              lit = `MCR_C_COLON;
            end else if (sub_q < `MCR_T_SEC) begin
              use_dig = 1'b1;
              dval = {4'h0, test_min};
              soff = sub_q - `MCR_T_MIN;
            end else if (sub_q < `MCR_T_LAST) begin
              use_dig = 1'b1;
              dval = {4'h0, test_sec};
              soff = sub_q - `MCR_T_SEC;
            end else begin
              lit = `MCR_C_SEMI;
            end
          end
        end else if (seg_q == 4'h1) begin
          if (sub_q == 4'h0) begin
            lit = `MCR_C_S;
          end else if (!sys_leak_avail) begin
            lit = (sub_q == 4'h1) ? `MCR_C_DASH : `MCR_C_SEMI;
            seg_end = (sub_q == 4'h2);
          end else if (sub_q == 4'h1) begin
            lit = `MCR_C_EQ;
          end else if (sub_q < 4'h5) begin
            use_dig = 1'b1;
            dval = sys_leak;
            soff = sub_q - 4'h2;
          end else begin
            lit = `MCR_C_SEMI;
            seg_end = 1'b1;
          end
        end else begin
          body_end = (seg_q == `MCR_TPORT_SEG);
          if (sub_q == 4'h0) begin
            lit = type_ch(ptype, pdis);
          end else if (sub_q == 4'h1) begin
            lit = port_open[pi] ? `MCR_C_PLUS : `MCR_C_DASH;
          end else if (!is_ioc(ptype)) begin
            lit = `MCR_C_SEMI;
            seg_end = 1'b1;
          end else if (sub_q == 4'h2) begin
            lit = port_in_use[pi] ? `MCR_C_PLUS : `MCR_C_DASH;
          end else if (!port_leak_avail[pi]) begin
            lit = (sub_q == 4'h3) ? `MCR_C_DASH : `MCR_C_SEMI;
            seg_end = (sub_q == 4'h4);
          end else if (sub_q == 4'h3) begin
            lit = `MCR_C_EQ;
          end else if (sub_q < `MCR_ST_SIGN) begin
            use_dig = 1'b1;
            dval = port_leak[pi * `MCR_VAL_W +: `MCR_VAL_W];
            soff = sub_q - `MCR_T_RATE;
          end else begin
            lit = `MCR_C_SEMI;
            seg_end = 1'b1;
          end
        end
      end
      `MCR_CMD_MSG: begin
        seg_end = (sub_q == 4'h1);
        if (seg_q == `MCR_MSG_NONE) begin
          lit = `MCR_C_X;
          skip = |msg_flags;
          body_end = 1'b1;
        end else begin
          lit = msg_ch(seg_q[2:0], sub_q[0]);
          skip = ~msg_flags[seg_q[2:0]];
          body_end = (|msg_flags) & (seg_q[2:0] == top_flag(msg_flags));
        end
      end
      `MCR_CMD_ID, `MCR_CMD_FW, `MCR_CMD_SN: begin
        if (cmd_q == `MCR_CMD_FW) begin
          str = (seg_q == 4'h0) ? FW_MAIN : FW_COMM;
          term = (seg_q == 4'h0);
          body_end = (seg_q == 4'h1);
        end else if (cmd_q == `MCR_CMD_SN) begin
          str = (seg_q == 4'h0) ? BOARD_SN : ((seg_q == 4'h1) ? PART_NO : UNIT_SN);
          term = (seg_q != 4'h2);
          body_end = (seg_q == 4'h2);
        end else begin
          body_end = 1'b1;
        end
        seg_end = term ? (sub_q == `MCR_STR_TERM) : (sub_q == `MCR_STR_LAST);
        lit = (sub_q == `MCR_STR_TERM) ? `MCR_C_SEMI : str[(`MCR_STR_LAST - sub_q) * 8 +: 8];
      end
      `MCR_CMD_LIM: begin
        seg_end = (sub_q == `MCR_LIM_LAST);
        body_end = seg_end;
        if (sub_q == 4'h0) begin
          lit = units_metric ? `MCR_C_M : `MCR_C_E;
        end else begin
          lk = (sub_q - 4'h1) / 4'h3;
          use_dig = 1'b1;
          dval = limits[lk * `MCR_VAL_W +: `MCR_VAL_W];
          soff = (sub_q - 4'h1) % 4'h3;
        end
      end
      default: begin
        lit = type_ch(port_type[sub_q[2:0] * `MCR_TYPE_W +: `MCR_TYPE_W], port_disabled[sub_q[2:0]]);
        seg_end = (sub_q == `MCR_CFG_LAST);
        body_end = seg_end;
      end
    endcase
  end

  // ****************************************
  // Reply sequencer
  // ****************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      hpos_q <= `MCR_POS_MARK;
      seg_q <= 4'h0;
      sub_q <= 4'h0;
      idx_q <= 8'h00;
      cmd_q <= 8'h00;
      rc_q <= `MCR_RC_Q;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_last_q <= 1'b0;
      start_test_q <= 1'b0;
      stop_test_q <= 1'b0;
      go_standby_q <= 1'b0;
      go_online_q <= 1'b0;
    end else begin
      start_test_q <= 1'b0;
      stop_test_q <= 1'b0;
      go_standby_q <= 1'b0;
      go_online_q <= 1'b0;
      if (tx_valid_q && tx_ready) begin
        tx_valid_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          // Frames without the command marker get no reply at all
          if (req && req_mark_ok) begin
            idx_q <= req_idx;
            cmd_q <= req_cmd;
            rc_q <= rc_d;
            hpos_q <= `MCR_POS_MARK;
            seg_q <= 4'h0;
            sub_q <= 4'h0;
            state_q <= S_HDR;
            start_test_q <= (req_cmd == `MCR_CMD_START) & can_test;
            stop_test_q <= (req_cmd == `MCR_CMD_STOP);
            go_standby_q <= (req_cmd == `MCR_CMD_STBY) & can_standby;
            go_online_q <= (req_cmd == `MCR_CMD_ONL);
          end
        end
        S_HDR: begin
          if (adv) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= (hpos_q == `MCR_POS_MARK) ? rc_q : ((hpos_q == `MCR_POS_IDX) ? idx_q : cmd_q);
            tx_last_q <= (hpos_q == `MCR_POS_CMD) & ~has_body;
            hpos_q <= hpos_q + 2'h1;
            if (hpos_q == `MCR_POS_CMD) begin
              state_q <= has_body ? S_BODY : S_DONE;
            end
          end
        end
        S_BODY: begin
          if (skip) begin
            seg_q <= seg_q + 4'h1;
          end else if (adv) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= body_ch;
            tx_last_q <= seg_end & body_end;
            if (seg_end) begin
              seg_q <= seg_q + 4'h1;
              sub_q <= 4'h0;
            end else begin
              sub_q <= sub_q + 4'h1;
            end
            if (seg_end && body_end) begin
              state_q <= S_DONE;
            end
          end
        end
        S_DONE: begin
          if (adv) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // mcr_responder
`default_nettype wire

// >>> mcr_responder_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.vh"
module mcr_responder_props (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Streams
  input wire rx_ready,
  input wire tx_valid_q,
  input wire [7:0] tx_data_q,
  input wire tx_last_q,
  input wire tx_ready,
  // Actions
  input wire can_test,
  input wire can_standby,
  input wire start_test_q,
  input wire stop_test_q,
  input wire go_standby_q,
  input wire go_online_q
);
  wire act = start_test_q | stop_test_q | go_standby_q | go_online_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****
  // Reply stream and strobes
  // ****
  a_byte_held: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_data_q))
    else $error("reply byte changed before accept");
  a_code_first: assert property ($fell(rx_ready) |=> tx_valid_q && tx_data_q inside {`MCR_RC_Y, `MCR_RC_N, `MCR_RC_Q})
    else $error("reply does not lead with a code");
  a_last_close: assert property (tx_valid_q && tx_ready && tx_last_q |=> !tx_valid_q)
    else $error("reply runs past last byte");
  a_idle_quiet: assert property (rx_ready |-> !tx_valid_q)
    else $error("request taken while replying");
  a_start_gate: assert property (start_test_q |-> $past(can_test))
    else $error("test started while not allowed");
  a_stby_gate: assert property (go_standby_q |-> $past(can_standby))
    else $error("standby entered while not allowed");
  a_act_accept: assert property (act |=> tx_valid_q && tx_data_q == `MCR_RC_Y)
    else $error("acted upon without accept code");
  a_act_pulse: assert property (act |=> !act)
    else $error("action strobe longer than one cycle");
endmodule // mcr_responder_props
bind mcr_responder mcr_responder_props u_props (.*);
`default_nettype wire

// >>> mcr_responder_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin fail_count++; $display("mismatch %s exp %h got %h", n, e, g); end end
module mcr_responder_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic units_metric = '0, temp_eng_neg = '0, temp_met_neg = '0, duty_avail = '0;
  logic test_done = '0, sys_leak_avail = '0, can_test = '0, can_standby = '0;
  logic [2:0] active_port = '0;
  logic [3:0] op_state = '0;
  logic [5:0] test_min = '0, test_sec = '0;
  logic [6:0] msg_flags = '0;
  logic [7:0] port_disabled = '0, port_open = '0, port_in_use = '0, port_leak_avail = '0;
  logic [9:0] press_eng = '0, press_met = '0, temp_eng = '0, temp_met = '0, duty = '0, test_hours = '0, sys_leak = '0;
  logic [15:0] global_alarm = '0;
  logic [23:0] port_type = '0;
  logic [39:0] limits = '0;
  logic [63:0] port_alarm = '0;
  logic [79:0] port_leak = '0;
  wire rx_valid, rx_last, rx_ready, tx_valid_q, tx_last_q, tx_ready;
  wire start_test_q, stop_test_q, go_standby_q, go_online_q;
  wire [7:0] rx_data, tx_data_q;
  integer fail_count = 0;
  integer total_checks = 0;
  mcr_responder dut (.*);
  mcr_host_model host (.*);
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task summarize;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // A frame that earns no reply simply waits out the bound
  task txn(input [63:0] f, input integer n, input [255:0] e, input integer en);
    integer w;
    begin
      host.clear();
      host.send(f, n);
      for (w = 0; w < 300 && !host.fin; w++) @(negedge core_clk);
      @(posedge core_clk);
      `CHK("reply", e, host.rep)
      `CHK("length", en, host.cnt)
    end
  endtask
  task t_status;
    begin
      units_metric <= 1'b1;
      active_port <= 3'h2;
      global_alarm <= 16'h0005;
      press_met <= 10'h07B;
      temp_met_neg <= 1'b1;
      temp_met <= 10'h02D;
      press_eng <= 10'h3FF;
      temp_eng <= 10'h007;
      duty <= 10'h02A;
      @(posedge core_clk);
      txn({8'h43, "A1"}, 3, "YA1MR3A123-045---", 17);
      host.slow = 1'b1;
      global_alarm <= 16'h0000;
      op_state <= 4'h1;
      duty_avail <= 1'b1;
      txn({8'h43, "BE"}, 3, "YBEEP_-999+007042", 17);
      host.slow = 1'b0;
    end
  endtask
  task t_alarms;
    begin
      global_alarm <= 16'h0125;
      port_alarm <= 64'h39;
      port_disabled <= 8'h0A;
      port_type <= 24'hFFF688;
      @(posedge core_clk);
      txn({8'h43, "CL"}, 3, "YCL012539.0000.0000000000", 25);
      txn({8'h43, "DP"}, 3, "YDPIoCBXXXX", 11);
      txn({8'h43, "EN"}, 3, "YEN0125I39o00C00B00X00X00X00X00", 31);
    end
  endtask
  task t_msgs;
    begin
      txn({8'h43, "FG"}, 3, "YFGXX", 5);
      msg_flags <= 7'h41;
      txn({8'h43, "FG"}, 3, "YFGXDTA", 7);
      port_type <= '1;
      txn({8'h43, "JT"}, 3, "YJTX;S-;X-;X-;X-;X-;X-;X-;X-;X-;", 32);
      txn({8'h43, "KC"}, 3, "YKCM000000000000", 16);
      txn({8'h43, "K0"}, 3, "YK0MCR-0001", 11);
    end
  endtask
  task t_actions;
    logic [47:0] c;
    logic [47:0] r;
    integer i;
    begin
      c = "557768";
      r = "NYNYYY";
      for (i = 0; i < 6; i++) begin
        can_test <= i[0];
        can_standby <= i[0];
        @(posedge core_clk);
        txn({8'h43, "G", c[8*(5-i)+:8]}, 3, {r[8*(5-i)+:8], "G", c[8*(5-i)+:8]}, 3);
      end
      txn({8'h43, "HZ"}, 3, "?HZ", 3);
    end
  endtask
  task t_refuse;
    begin
      txn("DA1", 3, 0, 0);
      txn({8'h43, "A"}, 2, 0, 0);
    end
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_status;
    t_alarms;
    t_msgs;
    t_actions;
    t_refuse;
    summarize;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    summarize;
  end
endmodule // mcr_responder_tb
`default_nettype wire

// >>> mcr_rx_frame.v
`timescale 1ns/1ps
`default_nettype none
`include "mcr_map.vh"
module mcr_rx_frame (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Request byte stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_last,
  input wire rx_ready,
  // Parsed request
  output reg req_q,
  output reg mark_ok_q,
  output reg [7:0] idx_q,
  output reg [7:0] cmd_q
);
  reg [1:0] cnt_q;
  wire beat;

  assign beat = rx_valid & rx_ready;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      mark_ok_q <= 1'b0;
      idx_q <= 8'h00;
      cmd_q <= 8'h00;
      cnt_q <= `MCR_POS_MARK;
    end else begin
      req_q <= 1'b0;
      if (beat) begin
        if (cnt_q == `MCR_POS_MARK) begin
          mark_ok_q <= (rx_data == `MCR_MARK);
        end
        if (cnt_q == `MCR_POS_IDX) begin
          idx_q <= rx_data;
        end
        if (cnt_q == `MCR_POS_CMD) begin
          cmd_q <= rx_data;
        end
        // Trailing data bytes are taken but not counted; the count holds at the data position and no command uses them
        if (rx_last) begin
          cnt_q <= `MCR_POS_MARK;
          req_q <= (cnt_q >= `MCR_POS_CMD);
        end else if (cnt_q != `MCR_POS_DATA) begin
          cnt_q <= cnt_q + 2'h1;
        end
      end
    end
  end
endmodule // mcr_rx_frame
`default_nettype wire
